// file: core/scl_pkg.sv
// constants and types for the system configuration lock bank
package scl_pkg;
  // register byte offsets (low 12 address bits)
  localparam logic [11:0] SCL_OFS_REVISION  = 12'h000;
  localparam logic [11:0] SCL_OFS_PART_ID   = 12'h018;
  localparam logic [11:0] SCL_OFS_STARTUP   = 12'h020;
  localparam logic [11:0] SCL_OFS_KEY_FIRST = 12'h038;
  localparam logic [11:0] SCL_OFS_KEY_SEC   = 12'h03c;
  localparam logic [11:0] SCL_OFS_HOST_CTL  = 12'h040;
  localparam logic [11:0] SCL_OFS_DSP_CTL   = 12'h044;
  localparam logic [11:0] SCL_OFS_RAW_STAT  = 12'h0e0;
  localparam logic [11:0] SCL_OFS_EN_STAT   = 12'h0e4;
  localparam logic [11:0] SCL_OFS_EN_SET    = 12'h0e8;
  localparam logic [11:0] SCL_OFS_EN_CLR    = 12'h0ec;
  localparam logic [11:0] SCL_OFS_EOI       = 12'h0f0;

  // unlock keys
  localparam logic [31:0] SCL_KEY_FIRST = 32'h83e70b13;
  localparam logic [31:0] SCL_KEY_SEC   = 32'h95a4f1e0;

  // identity words: values arbitrary, chosen for this design
  localparam logic [31:0] SCL_REVISION_DEF = 32'h00010000;
  localparam logic [31:0] SCL_PART_ID_DEF  = 32'h00000001;

  // field positions and widths
  localparam int          SCL_PIN_W       = 16;
  localparam int          SCL_VEC_LSB     = 10;
  localparam int          SCL_VEC_W       = 22;
  localparam int          SCL_RELEASE_BIT = 0;
  localparam int          SCL_ADDR_BIT    = 1;
  localparam int          SCL_PROT_BIT    = 0;
  localparam int          SCL_EOI_W       = 8;

  // edges after reset release before the synchronised straps are valid
  localparam logic [1:0]  SCL_SYNC_WAIT   = 2'h2;

  // reset values
  localparam logic [31:0] SCL_DSP_CTL_RST = 32'h00700000;
  localparam logic        SCL_RELEASE_RST = 1'h0;

  // unlock sequence states
  typedef enum logic [2:0] {
    SCL_LOCKED    = 3'b001,
    SCL_HALF_OPEN = 3'b010,
    SCL_OPEN      = 3'b100
  } scl_lock_t;
endpackage : scl_pkg

// file: core/scl_bank.sv
// system configuration lock bank with apb slave
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// RL1: read-only fixed revision word, writes ignored
// RL2: read-only part identity word for software
// RL3: capture startup pins once after reset release, upper zero
// RL4: all but eoi readable, non-key writes blocked until unlocked
// RL5: software writes first key first
// RL6: second key after first unlocks writes
// RL7: any wrong key value relocks bank
// RL8: release bit zero holds application core reset
// RL9: software keeps release set, enables core elsewhere
// RL10: dsp vector bits 31-10, default 00700000h
// RL11: dsp local reset loads modified boot vector
// RL12: bad address or locked write raises violation
// RL13: raw status: bit1 address, bit0 protection
// RL14: raw status write one sets, upper zero
// RL15: enabled status shows masked, write one clears
// RL16: enable-set write one enables interrupt
// RL17: enable-clear write one disables interrupt
// RL18: software writes end-of-interrupt after service
// RL19: interrupt high when flag and enable set
module scl_bank
  import scl_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [SCL_PIN_W-1:0] startup_pins,
  input  wire logic                 dsp_local_reset,
  output logic                      core_release,
  output logic      [31:0]          dsp_boot_addr,
  output logic                      violation_irq
);

  typedef struct packed {
    logic [SCL_PIN_W-1:0] pin_s1;
    logic [SCL_PIN_W-1:0] pin_s2;
    logic                 dsr_s1;
    logic                 dsr_s2;
    logic                 dsr_prev;
    logic                 captured;
    logic [1:0]           cap_wait;
    logic [SCL_PIN_W-1:0] startup;
    scl_lock_t            lock;
    logic [31:0]          key_first;
    logic [31:0]          key_sec;
    logic                 release_bit;
    logic [SCL_VEC_W-1:0] vector;
    logic [1:0]           raw;
    logic [1:0]           enable;
    logic [SCL_EOI_W-1:0] eoi;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 slverr;
    logic                 irq;
    logic [31:0]          boot_addr;
  } scl_state_t;

  scl_state_t state_reg;
  scl_state_t state_next;

  // known register offset check, shared by write and error paths
  function automatic logic scl_mapped(input logic [11:0] a);
    unique case (a)
      SCL_OFS_REVISION, SCL_OFS_PART_ID, SCL_OFS_STARTUP,
      SCL_OFS_KEY_FIRST, SCL_OFS_KEY_SEC, SCL_OFS_HOST_CTL,
      SCL_OFS_DSP_CTL, SCL_OFS_RAW_STAT, SCL_OFS_EN_STAT,
      SCL_OFS_EN_SET, SCL_OFS_EN_CLR, SCL_OFS_EOI: scl_mapped = 1'b1;
      default:                                     scl_mapped = 1'b0;
    endcase
  endfunction

  // registers whose writes the lock guards; keys stay open so they can unlock
  function automatic logic scl_guarded(input logic [11:0] a);
    unique case (a)
      SCL_OFS_HOST_CTL, SCL_OFS_DSP_CTL, SCL_OFS_RAW_STAT, SCL_OFS_EN_STAT,
      SCL_OFS_EN_SET, SCL_OFS_EN_CLR, SCL_OFS_EOI: scl_guarded = 1'b1;
      default:                                     scl_guarded = 1'b0;
    endcase
  endfunction

  // boot address as seen by the dsp core
  function automatic logic [31:0] scl_vec_word(input logic [SCL_VEC_W-1:0] v);
    scl_vec_word = {v, {SCL_VEC_LSB{1'b0}}};
  endfunction

  // read mux, evaluated in the setup phase
  function automatic logic [31:0] scl_read(input scl_state_t s, input logic [11:0] a);
    scl_read = 32'h00000000;
    unique case (a)
      SCL_OFS_REVISION:  scl_read = SCL_REVISION_DEF;                   // RL1
      SCL_OFS_PART_ID:   scl_read = SCL_PART_ID_DEF;                    // RL2
      SCL_OFS_STARTUP:   scl_read = {16'h0000, s.startup};              // RL3
      SCL_OFS_KEY_FIRST: scl_read = s.key_first;
      SCL_OFS_KEY_SEC:   scl_read = s.key_sec;
      SCL_OFS_HOST_CTL:  scl_read = {31'h00000000, s.release_bit};
      SCL_OFS_DSP_CTL:   scl_read = scl_vec_word(s.vector);             // RL10
      SCL_OFS_RAW_STAT:  scl_read = {30'h00000000, s.raw};              // RL13
      SCL_OFS_EN_STAT:   scl_read = {30'h00000000, s.raw & s.enable};   // RL15
      SCL_OFS_EN_SET:    scl_read = {30'h00000000, s.enable};
      SCL_OFS_EN_CLR:    scl_read = {30'h00000000, s.enable};
      default:           scl_read = 32'h00000000;                       // eoi is write only
    endcase
  endfunction

  logic        setup_phase;
  logic        wr_commit;
  logic        wr_allowed;
  logic        addr_fault;
  logic        prot_fault;
  logic [1:0]  hw_set;

  always_comb begin
    setup_phase = psel & ~penable;
    // a write lands only at the edge where pready is seen high
    wr_commit   = psel & penable & pwrite & state_reg.ready;
    wr_allowed  = wr_commit & scl_mapped(paddr) &
                  (~scl_guarded(paddr) | (state_reg.lock == SCL_OPEN));   // RL4
    addr_fault  = psel & penable & state_reg.ready & ~scl_mapped(paddr);  // RL12
    prot_fault  = wr_commit & scl_guarded(paddr) & (state_reg.lock != SCL_OPEN); // RL12
    hw_set      = 2'b00;
    hw_set[SCL_ADDR_BIT] = addr_fault;
    hw_set[SCL_PROT_BIT] = prot_fault;
  end

  // next-state logic for the whole bank
  always_comb begin
    state_next = state_reg;

    // startup pins come from pads: two flops before use
    state_next.pin_s1   = startup_pins;
    state_next.pin_s2   = state_reg.pin_s1;
    state_next.dsr_s1   = dsp_local_reset;
    state_next.dsr_s2   = state_reg.dsr_s1;
    state_next.dsr_prev = state_reg.dsr_s2;

    // sample straps once, after sync settles post reset;
    // the sync flops reset to zero, so an early capture would read zero
    if (!state_reg.captured) begin
      if (state_reg.cap_wait == SCL_SYNC_WAIT) begin
        state_next.startup  = state_reg.pin_s2;               // RL3
        state_next.captured = 1'b1;
      end else begin
        state_next.cap_wait = state_reg.cap_wait + 2'h1;
      end
    end

    // apb answer: zero wait, ready rises in the access phase
    state_next.ready  = setup_phase;
    state_next.slverr = setup_phase & ~scl_mapped(paddr);
    state_next.rdata  = 32'h00000000;
    if (setup_phase && !pwrite) begin
      state_next.rdata = scl_read(state_reg, paddr);
    end

    // unlock sequence: keys always writable, wrong value relocks
    if (wr_commit && paddr == SCL_OFS_KEY_FIRST) begin
      state_next.key_first = pwdata;
      if (pwdata != SCL_KEY_FIRST) begin
        state_next.lock = SCL_LOCKED;                         // RL7
      end else if (state_reg.lock != SCL_OPEN) begin
        state_next.lock = SCL_HALF_OPEN;                      // RL5
      end
    end
    if (wr_commit && paddr == SCL_OFS_KEY_SEC) begin
      state_next.key_sec = pwdata;
      if (pwdata != SCL_KEY_SEC) begin
        state_next.lock = SCL_LOCKED;                         // RL7
      end else if (state_reg.lock == SCL_HALF_OPEN) begin
        state_next.lock = SCL_OPEN;                           // RL6
      end
    end

    // guarded writes, only when open
    if (wr_allowed) begin
      unique case (paddr)
        SCL_OFS_HOST_CTL: state_next.release_bit = pwdata[SCL_RELEASE_BIT];   // RL8
        SCL_OFS_DSP_CTL:  state_next.vector = pwdata[31:SCL_VEC_LSB];         // RL10
        SCL_OFS_RAW_STAT: state_next.raw = state_reg.raw | pwdata[1:0];       // RL14
        SCL_OFS_EN_STAT:  state_next.raw = state_reg.raw & ~pwdata[1:0];      // RL15
        SCL_OFS_EN_SET:   state_next.enable = state_reg.enable | pwdata[1:0]; // RL16
        SCL_OFS_EN_CLR:   state_next.enable = state_reg.enable & ~pwdata[1:0];// RL17
        SCL_OFS_EOI:      state_next.eoi = pwdata[SCL_EOI_W-1:0];             // RL18
        default:          state_next.eoi = state_reg.eoi;
      endcase
    end

    // hardware set applied last so it beats a same-cycle clear
    state_next.raw = state_next.raw | hw_set;                 // RL12

    // level interrupt from enabled flags, registered
    state_next.irq = |(state_next.raw & state_next.enable);   // RL19

    // dsp takes the programmed vector on a local reset request edge
    if (state_reg.dsr_s2 && !state_reg.dsr_prev) begin
      state_next.boot_addr = scl_vec_word(state_reg.vector);  // RL11
    end
  end

  // single state register, constants only under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg             <= '0;
      state_reg.lock        <= SCL_LOCKED;                    // RL4
      state_reg.release_bit <= SCL_RELEASE_RST;               // RL8
      state_reg.vector      <= SCL_DSP_CTL_RST[31:SCL_VEC_LSB];
      state_reg.boot_addr   <= SCL_DSP_CTL_RST;               // RL10
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  always_comb begin
    prdata        = state_reg.rdata;
    pready        = state_reg.ready;
    pslverr       = state_reg.slverr;
    core_release  = state_reg.release_bit;                    // RL8
    dsp_boot_addr = state_reg.boot_addr;
    violation_irq = state_reg.irq;
  end

endmodule // scl_bank

// file: tb/scl_bank_checker.sv
// concurrent checks on the lock bank ports
`timescale 1ns/1ps
module scl_bank_checker
  import scl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        core_release,
  input wire logic [31:0] dsp_boot_addr,
  input wire logic        violation_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read completing at one offset
  sequence s_rd(logic [11:0] a);
    pready && psel && penable && !pwrite && paddr == a;
  endsequence
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  property p_rev; s_rd(SCL_OFS_REVISION) |-> prdata == SCL_REVISION_DEF; endproperty
  property p_id; s_rd(SCL_OFS_PART_ID) |-> prdata == SCL_PART_ID_DEF; endproperty
  property p_boot; s_rd(SCL_OFS_STARTUP) |-> prdata[31:16] == 16'h0000; endproperty
  property p_host; s_rd(SCL_OFS_HOST_CTL) |-> prdata == {31'h0, core_release}; endproperty
  // release may move only right after a committed host write
  property p_rel; !$stable(core_release) |-> $past(pready) && $past(pwrite) && $past(paddr) == SCL_OFS_HOST_CTL;
  endproperty
  property p_dsp; dsp_boot_addr[9:0] == 10'h000; endproperty
  property p_raw; s_rd(SCL_OFS_RAW_STAT) |-> prdata[31:2] == 30'h0; endproperty
  // irq follows flag or enable edges, which only bus accesses make
  property p_irq; !$stable(violation_irq) |-> $past(pready) || $past(pready, 2); endproperty
  a_rdy: assert property (p_rdy) else $error("no access answer after setup");
  a_rev: assert property (p_rev) else $error("revision word wrong");
  a_id: assert property (p_id) else $error("identity word wrong");
  a_boot: assert property (p_boot) else $error("startup capture upper bits set");
  a_host: assert property (p_host) else $error("host control readback wrong");
  a_rel: assert property (p_rel) else $error("release moved without write");
  a_dsp: assert property (p_dsp) else $error("boot address low bits set");
  a_raw: assert property (p_raw) else $error("raw status upper bits set");
  a_irq: assert property (p_irq) else $error("irq moved without access");
endmodule // scl_bank_checker

bind scl_bank scl_bank_checker chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .core_release(core_release), .dsp_boot_addr(dsp_boot_addr),
  .violation_irq(violation_irq));

// file: tb/system_config_lock_bank_tb_top.sv
// self-checking bench for the lock bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module system_config_lock_bank_tb_top;
  import scl_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;} scl_row_t;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, dsp_local_reset = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, dsp_boot_addr, rd;
  logic        pready, pslverr, core_release, violation_irq, se;
  logic [15:0] startup_pins = 16'ha5c3;
  int          n_mismatch = 0, num_checks = 0;
  // write, address, data, expected read, expected error
  scl_row_t rows [28] = '{
    '{0, 12'h000, 32'h0, 32'h00010000, 0}, '{1, 12'h000, 32'hffffffff, 32'h0, 0}, '{0, 12'h000, 32'h0, 32'h00010000, 0},
    '{0, 12'h018, 32'h0, 32'h00000001, 0}, '{0, 12'h020, 32'h0, 32'h0000a5c3, 0}, '{1, 12'h040, 32'h1, 32'h0, 0},
    '{0, 12'h040, 32'h0, 32'h0, 0}, '{0, 12'h0e0, 32'h0, 32'h1, 0}, '{0, 12'h100, 32'h0, 32'h0, 1},
    '{0, 12'h0e0, 32'h0, 32'h3, 0}, '{1, 12'h038, 32'h83e70b13, 32'h0, 0}, '{1, 12'h03c, 32'h95a4f1e0, 32'h0, 0},
    '{1, 12'h040, 32'h1, 32'h0, 0}, '{0, 12'h040, 32'h0, 32'h1, 0}, '{1, 12'h044, 32'h12345678, 32'h0, 0},
    '{0, 12'h044, 32'h0, 32'h12345400, 0}, '{1, 12'h0e8, 32'h3, 32'h0, 0}, '{0, 12'h0e4, 32'h0, 32'h3, 0},
    '{1, 12'h0ec, 32'h1, 32'h0, 0}, '{0, 12'h0e4, 32'h0, 32'h2, 0}, '{1, 12'h0e4, 32'h2, 32'h0, 0},
    '{0, 12'h0e0, 32'h0, 32'h1, 0}, '{1, 12'h0e0, 32'h2, 32'h0, 0}, '{0, 12'h0e0, 32'h0, 32'h3, 0},
    '{1, 12'h0f0, 32'h0, 32'h0, 0}, '{1, 12'h038, 32'h0, 32'h0, 0}, '{1, 12'h040, 32'h0, 32'h0, 0},
    '{0, 12'h040, 32'h0, 32'h1, 0}};

  scl_bank dut_u (
    .clk             (clk),
    .rst_n           (rst_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .startup_pins    (startup_pins),
    .dsp_local_reset (dsp_local_reset),
    .core_release    (core_release),
    .dsp_boot_addr   (dsp_boot_addr),
    .violation_irq   (violation_irq)
  );

  always #50 clk = ~clk;

  // one apb transfer; the wait is bounded so a dead slave cannot hang it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    r = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence: reset, table of transfers, then hand-written cases
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(dsp_boot_addr, SCL_DSP_CTL_RST)
    `CHK(core_release, 1'b0)
    `CHK(violation_irq, 1'b0)
    for (int i = 0; i < 28; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, se);
      if (!rows[i].w) `CHK(rd, rows[i].e)
      `CHK(se, rows[i].s)
    end
    repeat (2) @(posedge clk);
    `CHK(violation_irq, 1'b1)
    `CHK(core_release, 1'b1)
    // boot vector reaches the core only on its local reset
    `CHK(dsp_boot_addr, SCL_DSP_CTL_RST)
    dsp_local_reset <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(dsp_boot_addr, 32'h12345400)
    // good first key, wrong second key relocks the bank
    apb(1'b1, SCL_OFS_KEY_FIRST, SCL_KEY_FIRST, rd, se);
    apb(1'b1, SCL_OFS_KEY_SEC, 32'h00000000, rd, se);
    apb(1'b1, SCL_OFS_HOST_CTL, 32'h00000000, rd, se);
    apb(1'b0, SCL_OFS_HOST_CTL, 32'h00000000, rd, se);
    `CHK(rd, 32'h00000001)
    // mid-run reset: outputs back to defaults, straps captured again
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(core_release, 1'b0)
    `CHK(dsp_boot_addr, SCL_DSP_CTL_RST)
    `CHK(violation_irq, 1'b0)
    apb(1'b0, SCL_OFS_STARTUP, 32'h00000000, rd, se);
    `CHK(rd, 32'h0000a5c3)
    // second key alone does not open the bank
    apb(1'b1, SCL_OFS_KEY_SEC, SCL_KEY_SEC, rd, se);
    apb(1'b1, SCL_OFS_HOST_CTL, 32'h00000001, rd, se);
    repeat (2) @(posedge clk);
    `CHK(core_release, 1'b0)
    results();
  end

  // watchdog well past the expected run time
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
endmodule // system_config_lock_bank_tb_top
